// ==== owl_defines.svh ====
`ifndef OWL_DEFINES_SVH
`define OWL_DEFINES_SVH

// Reference clock rate
`define OWL_CLK_MHZ 200

// Line timing in microseconds
`define OWL_T_BREAK_DET_US 170
`define OWL_T_BIT_THR_US 68
`define OWL_T_DW1_US 40
`define OWL_T_DW0_US 112
`define OWL_T_CYCD_US 205
`define OWL_T_CYCD_MIN_US 190
`define OWL_T_CYCD_MAX_US 250
`define OWL_T_DW1_MIN_US 32
`define OWL_T_DW1_MAX_US 50
`define OWL_T_DW0_MIN_US 80
`define OWL_T_DW0_MAX_US 145
`define OWL_T_RSPS_US 190
`define OWL_T_BUS_RST_US 1900000

// Microseconds to reference clock cycles
`define OWL_US2CYC(us) ((us) * `OWL_CLK_MHZ)

// Counter widths
`define OWL_TX_CNT_W 16
`define OWL_CNT_W 32

`endif

// ==== owl_pkg.sv ====
package owl_pkg;
  typedef enum logic [1:0] {
    OWL_ST_IDLE = 2'h0,
    OWL_ST_LOW = 2'h1,
    OWL_ST_TX = 2'h2
  } owl_state_t;

  typedef enum logic [1:0] {
    OWL_TX_IDLE = 2'h0,
    OWL_TX_LOW = 2'h1,
    OWL_TX_REL = 2'h3
  } owl_tx_state_t;
endpackage : owl_pkg

// ==== owl_tx_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface owl_tx_if;
  logic start;
  logic bit_val;
  logic ready;
  logic busy;
  logic drive;

  modport ctl (output start, output bit_val, input ready, input busy, input drive);
  modport drv (input start, input bit_val, output ready, output busy, output drive);
endinterface : owl_tx_if
`default_nettype wire

// ==== owl_tx.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "owl_defines.svh"
module owl_tx #(
  parameter int DW1_CYC = `OWL_US2CYC(`OWL_T_DW1_US),
  parameter int DW0_CYC = `OWL_US2CYC(`OWL_T_DW0_US),
  parameter int CYC_CYC = `OWL_US2CYC(`OWL_T_CYCD_US)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  owl_tx_if.drv tx
);
  import owl_pkg::*;

  localparam logic [`OWL_TX_CNT_W-1:0] DW1_LAST = `OWL_TX_CNT_W'(DW1_CYC - 1);
  localparam logic [`OWL_TX_CNT_W-1:0] DW0_LAST = `OWL_TX_CNT_W'(DW0_CYC - 1);
  localparam logic [`OWL_TX_CNT_W-1:0] CYC_LAST = `OWL_TX_CNT_W'(CYC_CYC - 1);

  owl_tx_state_t state, next_state;
  logic [`OWL_TX_CNT_W-1:0] cnt, next_cnt;
  logic bit_q, next_bit_q;

  assign tx.ready = (state == OWL_TX_IDLE) || (state == OWL_TX_REL && cnt == CYC_LAST);
  assign tx.busy = (state != OWL_TX_IDLE);
  assign tx.drive = (state == OWL_TX_LOW);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt + `OWL_TX_CNT_W'(1);
    next_bit_q = bit_q;
    unique case (state)
      OWL_TX_IDLE:
      begin
        next_cnt = '0;
      end
      OWL_TX_LOW:
      begin
        // Short low for a one, long low for a zero
        if (cnt == (bit_q ? DW1_LAST : DW0_LAST))
        begin
          next_state = OWL_TX_REL;
        end
      end
      OWL_TX_REL:
      begin
        // Whole bit cycle lasts the nominal period
        if (cnt == CYC_LAST)
        begin
          next_state = OWL_TX_IDLE;
          next_cnt = '0;
        end
      end
      default:
      begin
        next_state = OWL_TX_IDLE;
        next_cnt = '0;
      end
    endcase
    if (tx.start && tx.ready)
    begin
      next_state = OWL_TX_LOW;
      next_cnt = '0;
      next_bit_q = tx.bit_val;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= OWL_TX_IDLE;
      cnt <= '0;
      bit_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bit_q <= next_bit_q;
    end
  end

  // Helper counters for the checks below
  logic [`OWL_CNT_W-1:0] low_run;
  logic [`OWL_CNT_W-1:0] since_fall;
  logic drive_q;
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      low_run <= '0;
      since_fall <= '0;
      drive_q <= 1'b0;
    end
    else
    begin
      drive_q <= tx.drive;
      low_run <= tx.drive ? low_run + `OWL_CNT_W'(1) : '0;
      since_fall <= (tx.drive && !drive_q) ? `OWL_CNT_W'(1) : since_fall + `OWL_CNT_W'(1);
    end
  end

  tx_one_width_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!tx.drive && drive_q && bit_q) |->
      (low_run >= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_DW1_MIN_US)))
      && (low_run <= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_DW1_MAX_US))))
    else $error("Device one pulse width out of range");

  tx_zero_width_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (!tx.drive && drive_q && !bit_q) |->
      (low_run >= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_DW0_MIN_US)))
      && (low_run <= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_DW0_MAX_US))))
    else $error("Device zero pulse width out of range");

  tx_cycle_time_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state == OWL_TX_REL && tx.start && tx.ready) |=>
      (since_fall >= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_CYCD_MIN_US)))
      && (since_fall <= `OWL_CNT_W'(`OWL_US2CYC(`OWL_T_CYCD_MAX_US))))
    else $error("Device bit cycle out of range");
endmodule : owl_tx
`default_nettype wire

// ==== owl_link.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "owl_defines.svh"
module owl_link #(
  parameter int BREAK_CYC = `OWL_US2CYC(`OWL_T_BREAK_DET_US),
  parameter int THR_CYC = `OWL_US2CYC(`OWL_T_BIT_THR_US),
  parameter int RSPS_CYC = `OWL_US2CYC(`OWL_T_RSPS_US),
  parameter int BUS_RST_CYC = `OWL_US2CYC(`OWL_T_BUS_RST_US),
  parameter int DW1_CYC = `OWL_US2CYC(`OWL_T_DW1_US),
  parameter int DW0_CYC = `OWL_US2CYC(`OWL_T_DW0_US),
  parameter int CYC_CYC = `OWL_US2CYC(`OWL_T_CYCD_US)
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_line,
  output logic o_line_out,
  output logic o_line_oe_n,
  input wire logic i_tx_valid,
  input wire logic i_tx_bit,
  output logic o_tx_ready,
  output logic o_tx_busy,
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_break,
  output logic o_bus_reset,
  output owl_pkg::owl_state_t o_state
);
  import owl_pkg::*;

  localparam logic [`OWL_CNT_W-1:0] BREAK_LIM = `OWL_CNT_W'(BREAK_CYC);
  localparam logic [`OWL_CNT_W-1:0] THR_LIM = `OWL_CNT_W'(THR_CYC);
  localparam logic [`OWL_CNT_W-1:0] RSPS_LIM = `OWL_CNT_W'(RSPS_CYC);
  localparam logic [`OWL_CNT_W-1:0] RST_LIM = `OWL_CNT_W'(BUS_RST_CYC);
  localparam logic [`OWL_CNT_W-1:0] CNT_MAX = '1;

  owl_tx_if tx ();

  owl_tx #(
    .DW1_CYC(DW1_CYC),
    .DW0_CYC(DW0_CYC),
    .CYC_CYC(CYC_CYC)
  ) u_tx (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .tx(tx)
  );

  owl_state_t state, next_state;
  logic [`OWL_CNT_W-1:0] low_len, next_low_len;
  logic [`OWL_CNT_W-1:0] gap, next_gap;
  logic rst_seen, next_rst_seen;
  logic rx_valid, next_rx_valid;
  logic rx_bit, next_rx_bit;
  logic brk, next_brk;
  logic bus_rst, next_bus_rst;
  logic tx_ok;

  // Device responds only after a quiet gap, or chains straight into its next bit
  assign tx_ok = tx.ready
    && ((state == OWL_ST_IDLE && i_line && gap >= RSPS_LIM) || state == OWL_ST_TX);
  assign tx.start = i_tx_valid && tx_ok;
  assign tx.bit_val = i_tx_bit;

  assign o_tx_ready = tx_ok;
  assign o_tx_busy = tx.busy;
  assign o_line_out = 1'b0;
  assign o_line_oe_n = ~tx.drive;
  assign o_rx_valid = rx_valid;
  assign o_rx_bit = rx_bit;
  assign o_break = brk;
  assign o_bus_reset = bus_rst;
  assign o_state = state;

  always_comb
  begin
    next_state = state;
    next_low_len = low_len;
    next_gap = (gap == CNT_MAX) ? gap : gap + `OWL_CNT_W'(1);
    next_rst_seen = rst_seen;
    next_rx_valid = 1'b0;
    next_rx_bit = rx_bit;
    next_brk = 1'b0;
    next_bus_rst = 1'b0;
    unique case (state)
      OWL_ST_IDLE:
      begin
        if (tx.start)
        begin
          next_state = OWL_ST_TX;
        end
        else if (!i_line)
        begin
          next_state = OWL_ST_LOW;
          next_low_len = `OWL_CNT_W'(1);
        end
      end
      OWL_ST_LOW:
      begin
        if (low_len != CNT_MAX)
        begin
          next_low_len = low_len + `OWL_CNT_W'(1);
        end
        // Continuous low drops any half-received state
        // Only a line still low at the limit counts; a release on that edge is a plain break
        if (low_len == RST_LIM - `OWL_CNT_W'(1) && !rst_seen && !i_line)
        begin
          next_bus_rst = 1'b1;
          next_rst_seen = 1'b1;
        end
        if (i_line)
        begin
          next_state = OWL_ST_IDLE;
          next_gap = '0;
          next_rst_seen = 1'b0;
          if (!rst_seen)
          begin
            if (low_len >= BREAK_LIM)
            begin
              next_brk = 1'b1;
            end
            else
            begin
              next_rx_valid = 1'b1;
              next_rx_bit = (low_len < THR_LIM);
            end
          end
        end
      end
      OWL_ST_TX:
      begin
        // Own pulses are not received; quiet gap restarts when the transmitter goes idle at the end of the bit cycle
        if (!tx.busy)
        begin
          next_state = OWL_ST_IDLE;
          next_gap = '0;
        end
      end
      default:
      begin
        next_state = OWL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state <= OWL_ST_IDLE;
      low_len <= '0;
      gap <= '0;
      rst_seen <= 1'b0;
      rx_valid <= 1'b0;
      rx_bit <= 1'b0;
      brk <= 1'b0;
      bus_rst <= 1'b0;
    end
    else
    begin
      state <= next_state;
      low_len <= next_low_len;
      gap <= next_gap;
      rst_seen <= next_rst_seen;
      rx_valid <= next_rx_valid;
      rx_bit <= next_rx_bit;
      brk <= next_brk;
      bus_rst <= next_bus_rst;
    end
  end

  line_low_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !o_line_oe_n |-> (o_line_out == 1'b0) && (state == OWL_ST_TX))
    else $error("Line driven other than low by transmitter");

  resp_gap_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state == OWL_ST_IDLE && tx.start) |-> ($past(gap) >= RSPS_LIM - `OWL_CNT_W'(1))
      && $past(i_line))
    else $error("Response started before quiet gap elapsed");

  bus_reset_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_bus_reset |-> (low_len == RST_LIM) && $past(!i_line))
    else $error("Bus reset at wrong low length");

  rx_one_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_rx_valid && o_rx_bit) |-> ($past(low_len) < THR_LIM))
    else $error("Long pulse taken as one");

  rx_zero_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (o_rx_valid && !o_rx_bit) |-> ($past(low_len) >= THR_LIM) && ($past(low_len) < BREAK_LIM))
    else $error("Zero pulse width misclassified");

  rx_quiet_tx_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $past(state == OWL_ST_TX) && $past(tx.busy) |-> !o_rx_valid && !o_break)
    else $error("Own transmission received as host bit");
endmodule : owl_link
`default_nettype wire

// ==== owl_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module owl_host #(
  parameter int REC = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_line,
  output var logic o_pull
);
  int run = 0;
  int since = 0;
  int n_low = 0;
  int cyc_w = 0;
  int low_w [2];
  logic prev = 1'b1;

  initial o_pull = 1'b0;

  // Host only pulls low or lets go; the pullup restores high
  task automatic send_low(input int n);
    @(posedge i_ref_clk);
    o_pull <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    o_pull <= 1'b0;
    // Recovery and turnaround before anything else is sent
    repeat (REC) @(posedge i_ref_clk);
  endtask : send_low

  // Measures the device's low widths and its first bit cycle; no timeout on
  // the response, the caller decides how long to wait
  always @(posedge i_ref_clk)
  begin
    prev <= i_line;
    since <= since + 1;
    if (!i_line && !o_pull)
    begin
      run <= run + 1;
    end
    if (!i_line && prev && !o_pull)
    begin
      if (n_low == 1)
      begin
        cyc_w <= since + 1;
      end
      since <= 0;
    end
    if (i_line && !prev && run > 0)
    begin
      if (n_low < 2)
      begin
        low_w[n_low] <= run;
      end
      n_low <= n_low + 1;
      run <= 0;
    end
  end
endmodule : owl_host
`default_nettype wire

// ==== owl_link_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module owl_link_test;
  import owl_pkg::*;
  localparam int THR = 20;
  localparam int BRK = 60;
  localparam int BRST = 200;
  localparam int RSPS = 38000;
  logic i_ref_clk;
  logic i_rst;
  logic i_tx_valid;
  logic i_tx_bit;
  logic line_out, oe_n, tx_ready, tx_busy, rx_valid, rx_bit, brk, bus_rst, pull, last_bit;
  logic prev_line = 1'b1;
  owl_state_t state;
  wire logic line;
  int errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int rel_cyc = 0;
  int n_v = 0;
  int n_b = 0;
  int n_r = 0;

  assign line = (oe_n === 1'b0 || pull === 1'b1) ? 1'b0 : 1'b1;

  owl_link #(.BREAK_CYC(BRK), .THR_CYC(THR), .BUS_RST_CYC(BRST)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_line(line), .o_line_out(line_out),
    .o_line_oe_n(oe_n), .i_tx_valid(i_tx_valid), .i_tx_bit(i_tx_bit),
    .o_tx_ready(tx_ready), .o_tx_busy(tx_busy), .o_rx_valid(rx_valid),
    .o_rx_bit(rx_bit), .o_break(brk), .o_bus_reset(bus_rst), .o_state(state));
  owl_host #(.REC(10)) u_host (.i_ref_clk(i_ref_clk), .i_line(line), .o_pull(pull));

  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end

  always @(posedge i_ref_clk)
  begin
    cyc <= cyc + 1;
    prev_line <= line;
    if (line === 1'b1 && prev_line === 1'b0) rel_cyc <= cyc;
    if (rx_valid === 1'b1) n_v <= n_v + 1;
    if (rx_valid === 1'b1) last_bit <= rx_bit;
    if (brk === 1'b1) n_b <= n_b + 1;
    if (bus_rst === 1'b1) n_r <= n_r + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] inr(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction : inr

  task automatic close_out();
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // Code 2 means a break is expected, otherwise the bit value
  task automatic rx_case(input int len, input logic [1:0] code);
    int v0;
    int b0;
    v0 = n_v;
    b0 = n_b;
    u_host.send_low(len);
    @(negedge i_ref_clk);
    check(n_v - v0, (code == 2'h2) ? 32'h0 : 32'h1);
    check(n_b - b0, (code == 2'h2) ? 32'h1 : 32'h0);
    if (code != 2'h2) check(last_bit, code[0]);
  endtask : rx_case

  task automatic t_bus_reset();
    int v0;
    int b0;
    int r0;
    v0 = n_v;
    b0 = n_b;
    r0 = n_r;
    u_host.send_low(BRST + 10);
    @(negedge i_ref_clk);
    check(n_r - r0, 32'h1);
    check((n_v - v0) + (n_b - b0), 32'h0);
    check(state, OWL_ST_IDLE);
  endtask : t_bus_reset

  task automatic wait_ready(input int lim);
    int k;
    for (k = 0; k < lim && tx_ready !== 1'b1; k++) @(negedge i_ref_clk);
    check(tx_ready, 32'h1);
  endtask : wait_ready

  task automatic t_tx();
    int k;
    @(posedge i_ref_clk);
    i_tx_bit <= 1'b0;
    i_tx_valid <= 1'b1;
    @(negedge i_ref_clk);
    check(tx_ready, 32'h0);
    wait_ready(RSPS + 100);
    check(inr(cyc - rel_cyc, RSPS - 2, RSPS + 100), 32'h1);
    @(posedge i_ref_clk);
    i_tx_bit <= 1'b1;
    @(negedge i_ref_clk);
    check(tx_busy, 32'h1);
    check(oe_n, 32'h0);
    check(state, OWL_ST_TX);
    wait_ready(50000);
    @(posedge i_ref_clk);
    i_tx_valid <= 1'b0;
    for (k = 0; k < 20000 && u_host.n_low < 2; k++) @(negedge i_ref_clk);
    check(inr(u_host.low_w[0], 16000, 29000), 32'h1);
    check(inr(u_host.low_w[1], 6400, 10000), 32'h1);
    check(inr(u_host.cyc_w, 38000, 50000), 32'h1);
    check(line_out, 32'h0);
  endtask : t_tx

  initial
  begin
    i_rst = 1'b1;
    i_tx_valid = 1'b0;
    i_tx_bit = 1'b0;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    @(negedge i_ref_clk);
    check(oe_n, 32'h1);
    check(state, OWL_ST_IDLE);
    rx_case(1, 2'h1);
    rx_case(THR - 1, 2'h1);
    rx_case(THR, 2'h0);
    rx_case(BRK - 1, 2'h0);
    rx_case(BRK, 2'h2);
    t_bus_reset();
    t_tx();
    close_out();
  end

  // Run should need about 88000 cycles
  initial
  begin
    repeat (99000) @(posedge i_ref_clk);
    errors++;
    close_out();
  end
endmodule : owl_link_test
`default_nettype wire
